/* File: logic/input_cfg_pkg.sv */
// constants, field layouts and carriers for the input and calibration parameter store
package input_cfg_pkg;
	// clock and long timing
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned LOCK_MINUTES = 10;
	localparam longint unsigned LOCK_CYCLES = longint'(LOCK_MINUTES) * 64'd60 * longint'(CLK_HZ);
	localparam int unsigned PW_TRIES = 5;
	localparam logic [2:0] PW_LAST_TRY = 3'h4;

	// register byte offsets
	localparam logic [7:0] OFS_INPUT = 8'h00;
	localparam logic [7:0] OFS_SMOOTH = 8'h04;
	localparam logic [7:0] OFS_CORR = 8'h08;
	localparam logic [7:0] OFS_SP_FLOOR = 8'h0C;
	localparam logic [7:0] OFS_SP_CEIL = 8'h10;
	localparam logic [7:0] OFS_SETPOINT = 8'h14;
	localparam logic [7:0] OFS_LOOP_BREAK = 8'h18;
	localparam logic [7:0] OFS_FAIL_PCT = 8'h1C;
	localparam logic [7:0] OFS_LINK = 8'h20;
	localparam logic [7:0] OFS_CAL_EN = 8'h24;
	localparam logic [7:0] OFS_LOW_TRIM = 8'h28;
	localparam logic [7:0] OFS_HIGH_TRIM = 8'h2C;
	localparam logic [7:0] OFS_RELOAD = 8'h30;
	localparam logic [7:0] OFS_COLD_JCT = 8'h34;
	localparam logic [7:0] OFS_PW_ENTRY = 8'h38;
	localparam logic [7:0] OFS_PW_UPDATE = 8'h3C;
	localparam logic [7:0] OFS_PROT = 8'h40;
	localparam logic [7:0] OFS_STATUS = 8'h44;

	// field positions
	localparam int POS_KIND = 0;
	localparam int POS_FAHR = 4;
	localparam int POS_DEC = 8;
	localparam int POS_SPEED = 0;
	localparam int POS_PARITY = 4;
	localparam int POS_NODE = 8;

	// limits
	localparam logic [4:0] SMOOTH_MAX = 5'h14;
	localparam logic [6:0] PCT_MAX = 7'h64;
	localparam logic [7:0] NODE_MIN = 8'h01;
	localparam logic [7:0] NODE_MAX = 8'hF7;
	localparam logic [1:0] PARITY_ODD = 2'h2;
	localparam logic [2:0] PROT_MIN = 3'h1;
	localparam logic [2:0] PROT_INPUT = 3'h2;
	localparam logic [2:0] PROT_SP = 3'h6;

	// spans per sensor kind, degrees Celsius
	localparam logic [15:0] SPAN_TC_J = 16'h03B6;
	localparam logic [15:0] SPAN_TC_K = 16'h055A;
	localparam logic [15:0] SPAN_TC_T = 16'h0190;
	localparam logic [15:0] SPAN_RTD = 16'h0352;

	// values after reset
	localparam logic [15:0] RST_PASSWORD = 16'h0457;
	localparam logic [15:0] RST_SP_FLOOR = 16'hFF92;
	localparam logic [15:0] RST_SP_CEIL = 16'h03B6;
	localparam logic [15:0] RST_LOOP_BREAK = 16'h0000;
	localparam logic [2:0] RST_SPEED = 3'h3;
	localparam logic [7:0] RST_NODE = 8'h01;
	localparam logic [2:0] RST_PROT = 3'h1;
	localparam logic [15:0] RST_LOW_TRIM = 16'h0000;
	localparam logic [15:0] RST_HIGH_TRIM = 16'h0000;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] sensor_kind_select;
		logic fahrenheit;
		logic [1:0] decimal_place_select;
		logic [4:0] smoothing_strength;
	} input_cfg_t;

	typedef struct packed {
		logic [2:0] link_speed_select;
		logic [1:0] parity_mode;
		logic [7:0] node_number;
	} link_cfg_t;
endpackage : input_cfg_pkg

/* File: logic/process_input_config_bank.sv */
// input and calibration parameter store with password protection, on an Avalon-MM slave
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - four sensor kinds, three thermocouples and one RTD, each with own span.
// - smoothing accepts 0 to 20; zero is off, 20 strongest.
// - one decimal place setting serves both process value and setpoint.
// - scale bit selects Celsius or Fahrenheit presentation.
// - correction value is added to every reading; it resets to zero.
// - setpoint is confined between the stored floor and ceiling.
// - loop-break interval in minutes is kept for the loop fault logic.
// - on sensor failure the output takes the stored fallback percentage.
// - link speed selects one of eight rates from 1.2 to 115.2 kbit/s.
// - link speed, parity and node exist only with the serial option.
// - parity offers none, even or odd.
// - node number accepted only from 1 to 247.
// - password entry must pass before protected groups can be changed.
// - trims are hidden while calibration enable is off.
// - operator enters low and high point readings; both trim the input.
// - reload command restores factory trims, dropping user calibration.
// - cold junction reading is read only.
// - password update stores a new password and rejects zero.
// - protection level selects which groups need the password.
// - levels 1 to 6; 1 guards calibration, 6 also guards setpoint.
// - stored password resets to 1111.
// - five wrong entries in a row lock out access for ten minutes.
module process_input_config_bank #(
	parameter longint unsigned LOCKOUT_CYCLES = input_cfg_pkg::LOCK_CYCLES,
	parameter logic [15:0] FACTORY_LOW_TRIM = input_cfg_pkg::RST_LOW_TRIM,
	parameter logic [15:0] FACTORY_HIGH_TRIM = input_cfg_pkg::RST_HIGH_TRIM
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	// pins
	input wire logic sensor_fail_pin,
	input wire logic serial_fitted_pin,
	// measurement and control side
	input wire logic signed [15:0] pv_raw,
	input wire logic signed [15:0] cold_junction,
	input wire logic [6:0] control_pct,
	output logic signed [15:0] pv_corrected,
	output logic [6:0] output_pct,
	output input_cfg_pkg::input_cfg_t input_cfg,
	output input_cfg_pkg::link_cfg_t link_cfg,
	output logic [15:0] sensor_span,
	output logic signed [15:0] setpoint,
	output logic [15:0] loop_break_minutes,
	output logic signed [15:0] low_point_trim,
	output logic signed [15:0] high_point_trim,
	output logic access_locked
);
	import input_cfg_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] span_of(input logic [1:0] kind);
		unique case (kind)
			2'h0: span_of = SPAN_TC_J;
			2'h1: span_of = SPAN_TC_K;
			2'h2: span_of = SPAN_TC_T;
			default: span_of = SPAN_RTD;
		endcase
	endfunction : span_of

	function automatic logic signed [15:0] clamp(input logic signed [15:0] v, input logic signed [15:0] lo,
		input logic signed [15:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic fail_meta_q, fail_s_q, fit_meta_q, fit_s_q;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			fail_meta_q <= 1'b0;
			fail_s_q <= 1'b0;
			fit_meta_q <= 1'b0;
			fit_s_q <= 1'b0;
		end
		else
		begin
			fail_meta_q <= sensor_fail_pin;
			fail_s_q <= fail_meta_q;
			fit_meta_q <= serial_fitted_pin;
			fit_s_q <= fit_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus handshake: one wait cycle, write takes effect on the edge that sees waitrequest low
	logic wait_q;
	logic [31:0] rdata_q;
	logic [1:0] resp_q;
	logic [31:0] rd_word;
	logic rd_hit;
	wire req = (avs_read | avs_write) & wait_q;
	wire wr_go = avs_write & ~wait_q & (avs_address[1:0] == 2'h0) & (avs_byteenable[1:0] == 2'h3);
	wire [15:0] wd = avs_writedata[15:0];
	wire signed [15:0] wd_s = avs_writedata[15:0];

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			resp_q <= RESP_OKAY;
		end
		else
		begin
			wait_q <= ~req;
			if (req)
			begin
				rdata_q <= avs_read ? rd_word : 32'h0000_0000;
				resp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// password, unlock and lockout state
	logic [15:0] pass_q;
	logic unlocked_q, locked_q;
	logic [2:0] fails_q;
	logic [33:0] lock_cnt_q;
	logic [2:0] prot_q;
	logic cal_en_q;

	// calibration group is always guarded; lockout drops the unlock, groups the protection level leaves open stay writable
	wire cal_ok = unlocked_q & ~locked_q;
	wire in_ok = (prot_q < PROT_INPUT) | cal_ok;
	wire sp_ok = (prot_q < PROT_SP) | cal_ok;
	wire pw_go = wr_go & (avs_address == OFS_PW_ENTRY) & ~locked_q;
	wire pw_match = (wd == pass_q);

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			unlocked_q <= 1'b0;
			fails_q <= 3'h0;
			locked_q <= 1'b0;
			lock_cnt_q <= 34'h0;
		end
		else if (locked_q)
		begin
			unlocked_q <= 1'b0;
			lock_cnt_q <= lock_cnt_q - 34'h1;
			locked_q <= (lock_cnt_q != 34'h0);
		end
		else if (pw_go)
		begin
			unlocked_q <= pw_match;
			fails_q <= (pw_match || fails_q == PW_LAST_TRY) ? 3'h0 : fails_q + 3'h1;
			locked_q <= ~pw_match & (fails_q == PW_LAST_TRY);
			lock_cnt_q <= 34'(LOCKOUT_CYCLES - 64'd1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// calibration group
	logic signed [15:0] low_trim_q, high_trim_q;
	wire cal_wr = wr_go & cal_ok;
	wire reload_go = cal_wr & (avs_address == OFS_RELOAD) & wd[0];
	wire trim_wr = cal_wr & cal_en_q;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			pass_q <= RST_PASSWORD;
			prot_q <= RST_PROT;
			cal_en_q <= 1'b0;
			low_trim_q <= RST_LOW_TRIM;
			high_trim_q <= RST_HIGH_TRIM;
		end
		else
		begin
			if (cal_wr && avs_address == OFS_PW_UPDATE && wd != 16'h0000)
				pass_q <= wd;
			if (cal_wr && avs_address == OFS_PROT && wd[2:0] >= PROT_MIN && wd[2:0] <= PROT_SP && wd[15:3] == 13'h0)
				prot_q <= wd[2:0];
			if (cal_wr && avs_address == OFS_CAL_EN)
				cal_en_q <= wd[0];
			if (reload_go)
			begin
				low_trim_q <= FACTORY_LOW_TRIM;
				high_trim_q <= FACTORY_HIGH_TRIM;
			end
			else
			begin
				if (trim_wr && avs_address == OFS_LOW_TRIM)
					low_trim_q <= wd_s;
				if (trim_wr && avs_address == OFS_HIGH_TRIM)
					high_trim_q <= wd_s;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// input group
	input_cfg_t cfg_q;
	link_cfg_t link_q;
	logic signed [15:0] corr_q, floor_q, ceil_q, sp_q;
	logic [15:0] lbd_q;
	logic [6:0] fail_pct_q;
	wire in_wr = wr_go & in_ok;
	wire link_wr = in_wr & fit_s_q & (avs_address == OFS_LINK);
	wire [1:0] new_par = wd[POS_PARITY +: 2];
	wire [7:0] new_node = wd[POS_NODE +: 8];
	wire link_ok = (new_par <= PARITY_ODD) & (new_node >= NODE_MIN) & (new_node <= NODE_MAX);
	wire sp_go = wr_go & sp_ok & (avs_address == OFS_SETPOINT);

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_q <= '0;
			link_q <= '{link_speed_select: RST_SPEED, parity_mode: 2'h0, node_number: RST_NODE};
			corr_q <= 16'sh0000;
			floor_q <= RST_SP_FLOOR;
			ceil_q <= RST_SP_CEIL;
			lbd_q <= RST_LOOP_BREAK;
			fail_pct_q <= 7'h00;
		end
		else
		begin
			if (in_wr && avs_address == OFS_INPUT)
			begin
				cfg_q.sensor_kind_select <= wd[POS_KIND +: 2];
				cfg_q.fahrenheit <= wd[POS_FAHR];
				cfg_q.decimal_place_select <= wd[POS_DEC +: 2];
			end
			if (in_wr && avs_address == OFS_SMOOTH && wd <= 16'(SMOOTH_MAX))
				cfg_q.smoothing_strength <= wd[4:0];
			if (in_wr && avs_address == OFS_CORR)
				corr_q <= wd_s;
			// floor above ceiling would leave no legal setpoint
			if (in_wr && avs_address == OFS_SP_FLOOR && wd_s <= ceil_q)
				floor_q <= wd_s;
			if (in_wr && avs_address == OFS_SP_CEIL && wd_s >= floor_q)
				ceil_q <= wd_s;
			if (in_wr && avs_address == OFS_LOOP_BREAK)
				lbd_q <= wd;
			if (in_wr && avs_address == OFS_FAIL_PCT && wd <= 16'(PCT_MAX))
				fail_pct_q <= wd[6:0];
			if (link_wr && link_ok)
			begin
				link_q.link_speed_select <= wd[POS_SPEED +: 3];
				link_q.parity_mode <= new_par;
				link_q.node_number <= new_node;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// setpoint and measurement path
	logic signed [15:0] pv_q;
	logic [6:0] out_q;
	logic [15:0] span_q;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			sp_q <= RST_SP_FLOOR;
			pv_q <= 16'sh0000;
			out_q <= 7'h00;
			span_q <= SPAN_TC_J;
		end
		else
		begin
			// a narrowed window drags the setpoint back inside
			sp_q <= clamp(sp_go ? wd_s : sp_q, floor_q, ceil_q);
			pv_q <= 16'(pv_raw + corr_q);
			out_q <= fail_s_q ? fail_pct_q : control_pct;
			span_q <= span_of(cfg_q.sensor_kind_select);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux; guarded registers stay readable, hidden ones read zero
	wire [31:0] st_word = {24'h0, 1'b0, fails_q, fit_s_q, cal_en_q, locked_q, unlocked_q};

	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_hit = (avs_address[1:0] == 2'h0);
		unique case (avs_address)
			OFS_INPUT: rd_word = {22'h0, cfg_q.decimal_place_select, 3'h0, cfg_q.fahrenheit, 2'h0,
				cfg_q.sensor_kind_select};
			OFS_SMOOTH: rd_word = {27'h0, cfg_q.smoothing_strength};
			OFS_CORR: rd_word = {16'h0, corr_q};
			OFS_SP_FLOOR: rd_word = {16'h0, floor_q};
			OFS_SP_CEIL: rd_word = {16'h0, ceil_q};
			OFS_SETPOINT: rd_word = {16'h0, sp_q};
			OFS_LOOP_BREAK: rd_word = {16'h0, lbd_q};
			OFS_FAIL_PCT: rd_word = {25'h0, fail_pct_q};
			OFS_LINK: rd_word = fit_s_q ? {16'h0, link_q.node_number, 2'h0, link_q.parity_mode, 1'b0,
				link_q.link_speed_select} : 32'h0000_0000;
			OFS_CAL_EN: rd_word = {31'h0, cal_en_q};
			OFS_LOW_TRIM: rd_word = cal_en_q ? {16'h0, low_trim_q} : 32'h0000_0000;
			OFS_HIGH_TRIM: rd_word = cal_en_q ? {16'h0, high_trim_q} : 32'h0000_0000;
			OFS_RELOAD: rd_word = 32'h0000_0000;
			OFS_COLD_JCT: rd_word = {16'h0, cold_junction};
			OFS_PW_ENTRY: rd_word = 32'h0000_0000;
			OFS_PW_UPDATE: rd_word = 32'h0000_0000;
			OFS_PROT: rd_word = {29'h0, prot_q};
			OFS_STATUS: rd_word = st_word;
			default: rd_hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign avs_response = resp_q;
	assign pv_corrected = pv_q;
	assign output_pct = out_q;
	assign input_cfg = cfg_q;
	assign link_cfg = link_q;
	assign sensor_span = span_q;
	assign setpoint = sp_q;
	assign loop_break_minutes = lbd_q;
	assign low_point_trim = low_trim_q;
	assign high_point_trim = high_trim_q;
	assign access_locked = locked_q;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	chk_smooth_range: assert property (cfg_q.smoothing_strength <= SMOOTH_MAX)
		else $error("smoothing above limit");
	chk_pv_correct: assert property (!$past(rst) |-> pv_q == 16'($past(pv_raw) + $past(corr_q)))
		else $error("corrected reading mismatch");
	chk_sp_window: assert property (sp_go |=> (sp_q >= floor_q) && (sp_q <= ceil_q))
		else $error("setpoint outside window");
	chk_fail_output: assert property (fail_s_q |=> out_q == $past(fail_pct_q))
		else $error("fallback output not applied");
	chk_link_hidden: assert property (avs_read && wait_q && !fit_s_q && avs_address == OFS_LINK
		|=> avs_readdata == 32'h0000_0000)
		else $error("link settings visible without option");
	chk_node_range: assert property (link_q.node_number >= NODE_MIN && link_q.node_number <= NODE_MAX)
		else $error("node number out of range");
	chk_pw_nonzero: assert property (pass_q != 16'h0000)
		else $error("password became zero");
	chk_lock_after_five: assert property (pw_go && !pw_match && fails_q == PW_LAST_TRY
		|=> locked_q && !unlocked_q ##1 locked_q)
		else $error("lockout not entered");
	chk_guard_write: assert property (wr_go && avs_address == OFS_PROT && !cal_ok |=> $stable(prot_q))
		else $error("guarded write took effect");
	chk_wait_one: assert property (req |=> !wait_q ##1 wait_q)
		else $error("bus answer timing wrong");

	cov_lockout: cover property (pw_go && !pw_match && fails_q == PW_LAST_TRY);
	cov_unlock: cover property (pw_go && pw_match);
	cov_reload: cover property (reload_go);
	cov_sensor_fail: cover property ($rose(fail_s_q));
endmodule : process_input_config_bank

`default_nettype wire

/* File: tb/process_input_config_bank_bench.sv */
// self-checking bench for the input and calibration parameter store
`timescale 1ns/100ps
`default_nettype none
module process_input_config_bank_bench;
	import input_cfg_pkg::*;
	localparam longint unsigned LOCK = 40;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [1:0] avs_response;
	logic fail_in = 1'b0;
	logic fitted = 1'b1;
	logic signed [15:0] pv_raw = 16'h0000;
	logic signed [15:0] cold_j = 16'h0019;
	logic [6:0] ctl = 7'h4D;
	logic signed [15:0] pv_corr, sp, lo_t, hi_t;
	logic [6:0] out_pct;
	input_cfg_t icfg;
	link_cfg_t lcfg;
	logic [15:0] span, lbd;
	logic locked;
	logic [31:0] rd;
	logic [1:0] rsp;
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;

	always #25 core_clk = ~core_clk;

	process_input_config_bank #(.LOCKOUT_CYCLES(LOCK)) i_dut (
		.core_clk(core_clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
		.sensor_fail_pin(fail_in), .serial_fitted_pin(fitted),
		.pv_raw(pv_raw), .cold_junction(cold_j), .control_pct(ctl),
		.pv_corrected(pv_corr), .output_pct(out_pct), .input_cfg(icfg), .link_cfg(lcfg),
		.sensor_span(span), .setpoint(sp), .loop_break_minutes(lbd),
		.low_point_trim(lo_t), .high_point_trim(hi_t), .access_locked(locked)
	);

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask : chk

	// master holds the request until waitrequest is sampled low
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
	begin
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= we;
		avs_read <= !we;
		avs_writedata <= d;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		rsp = avs_response;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	end
	endtask : bus

	// one more edge so the written register has settled before anyone looks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
	begin
		bus(1'b1, a, d);
		@(posedge core_clk);
	end
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
	begin
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	end
	endtask : rdc

	task automatic settle();
		repeat (3) @(posedge core_clk);
	endtask : settle

	task automatic end_of_test();
	begin
		$display("checks %0d, errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask : end_of_test

	////////////////////////////////////////////////////////////////
	task automatic t_reset();
	begin
		chk(span, 32'h03B6);
		chk(sp, 32'hFFFFFF92);
		chk(lcfg, {19'h0, 3'h3, 2'h0, 8'h01});
		rdc(OFS_CORR, 32'h0);
		rdc(OFS_STATUS, 32'h8);
		rdc(8'h48, 32'h0);
		chk(rsp, RESP_SLVERR);
		rdc(8'h01, 32'h0);
		chk(rsp, RESP_SLVERR);
	end
	endtask : t_reset

	task automatic t_input();
		logic [15:0] spans [4];
	begin
		spans = '{16'h03B6, 16'h055A, 16'h0190, 16'h0352};
		wr(OFS_SMOOTH, 32'd21);
		rdc(OFS_SMOOTH, 32'h0);
		wr(OFS_SMOOTH, 32'd20);
		chk(icfg.smoothing_strength, 32'd20);
		for (int k = 0; k < 4; k++)
		begin
			wr(OFS_INPUT, k | (k[0] << 4) | (2 << 8));
			settle();
			chk(span, spans[k]);
			chk(icfg.fahrenheit, k[0]);
			chk(icfg.decimal_place_select, 32'h2);
		end
		wr(OFS_CORR, 32'h0000FFFB);
		pv_raw <= 16'sd100;
		settle();
		chk(pv_corr, 32'd95);
	end
	endtask : t_input

	task automatic t_setpoint();
	begin
		wr(OFS_SP_FLOOR, 32'h0);
		wr(OFS_SP_CEIL, 32'd100);
		wr(OFS_SETPOINT, 32'd500);
		settle();
		chk(sp, 32'd100);
		wr(OFS_SP_FLOOR, 32'd200);
		rdc(OFS_SP_FLOOR, 32'h0);
		wr(OFS_SP_CEIL, 32'd50);
		settle();
		chk(sp, 32'd50);
	end
	endtask : t_setpoint

	task automatic t_fail();
	begin
		wr(OFS_FAIL_PCT, 32'd40);
		wr(OFS_FAIL_PCT, 32'd101);
		avs_byteenable <= 4'hC;
		wr(OFS_FAIL_PCT, 32'd50);
		chk(rsp, RESP_OKAY);
		avs_byteenable <= 4'hF;
		rdc(OFS_FAIL_PCT, 32'd40);
		settle();
		chk(out_pct, 32'h4D);
		fail_in <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk(out_pct, 32'd40);
		fail_in <= 1'b0;
		wr(OFS_LOOP_BREAK, 32'd15);
		chk(lbd, 32'd15);
	end
	endtask : t_fail

	task automatic t_link();
		logic [31:0] bad [3];
	begin
		bad = '{32'h0000F737, 32'h00000017, 32'h0000F817};
		wr(OFS_LINK, 32'h0000F727);
		chk(lcfg, {19'h0, 3'h7, 2'h2, 8'hF7});
		wr(OFS_LINK, 32'h00000510);
		chk(lcfg, {19'h0, 3'h0, 2'h1, 8'h05});
		for (int i = 0; i < 3; i++)
		begin
			wr(OFS_LINK, bad[i]);
			rdc(OFS_LINK, 32'h00000510);
		end
		fitted <= 1'b0;
		settle();
		rdc(OFS_LINK, 32'h0);
		wr(OFS_LINK, 32'h00000900);
		fitted <= 1'b1;
		settle();
		rdc(OFS_LINK, 32'h00000510);
	end
	endtask : t_link

	task automatic t_cal();
	begin
		wr(OFS_CAL_EN, 32'h1);
		rdc(OFS_STATUS, 32'h8);
		wr(OFS_PW_ENTRY, 32'h0457);
		rdc(OFS_STATUS, 32'h9);
		wr(OFS_CAL_EN, 32'h1);
		wr(OFS_LOW_TRIM, 32'h10);
		wr(OFS_HIGH_TRIM, 32'h200);
		chk({lo_t, hi_t}, 32'h00100200);
		wr(OFS_CAL_EN, 32'h0);
		rdc(OFS_LOW_TRIM, 32'h0);
		wr(OFS_HIGH_TRIM, 32'h300);
		wr(OFS_CAL_EN, 32'h1);
		rdc(OFS_HIGH_TRIM, 32'h200);
		wr(OFS_RELOAD, 32'h1);
		settle();
		chk({lo_t, hi_t}, 32'h0);
		wr(OFS_COLD_JCT, 32'h55);
		rdc(OFS_COLD_JCT, 32'h19);
	end
	endtask : t_cal

	task automatic t_prot();
	begin
		wr(OFS_PW_UPDATE, 32'h0);
		wr(OFS_PW_ENTRY, 32'h0457);
		rdc(OFS_STATUS, 32'hD);
		wr(OFS_PW_UPDATE, 32'h1234);
		wr(OFS_PROT, 32'd6);
		wr(OFS_PW_ENTRY, 32'h0457);
		wr(OFS_SMOOTH, 32'd3);
		rdc(OFS_SMOOTH, 32'd20);
		wr(OFS_PROT, 32'd2);
		rdc(OFS_PROT, 32'd6);
		wr(OFS_SETPOINT, 32'd10);
		settle();
		chk(sp, 32'd50);
		wr(OFS_PW_ENTRY, 32'h1234);
		wr(OFS_SETPOINT, 32'd10);
		settle();
		chk(sp, 32'd10);
		wr(OFS_PROT, 32'd7);
		rdc(OFS_PROT, 32'd6);
		wr(OFS_PROT, 32'd1);
		for (int i = 0; i < 5; i++)
			wr(OFS_PW_ENTRY, 32'h0001);
		settle();
		chk(locked, 1'b1);
		wr(OFS_PW_ENTRY, 32'h1234);
		rdc(OFS_STATUS, 32'hE);
		repeat (LOCK) @(posedge core_clk);
		chk(locked, 1'b0);
		wr(OFS_PW_ENTRY, 32'h1234);
		rdc(OFS_STATUS, 32'hD);
	end
	endtask : t_prot

	////////////////////////////////////////////////////////////////
	// generous ceiling: the whole run needs well under a thousand cycles
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors++;
			end_of_test();
		end
	end

	initial
	begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		settle();
		t_reset();
		t_input();
		t_setpoint();
		t_fail();
		t_link();
		t_cal();
		t_prot();
		end_of_test();
	end
endmodule : process_input_config_bank_bench
`default_nettype wire
